// ### design/kme_pkg.sv
package kme_pkg;
    // ------------------------------------------------------------
    // matrix geometry and code layout
    // ------------------------------------------------------------
    localparam int X_LINES = 9;
    localparam int Y_LINES = 10;
    localparam int POS_W = 7;
    localparam int CODE_W = 9;
    localparam logic [1:0] MODE_NORMAL = 2'h0;
    localparam logic [1:0] MODE_SHIFT = 2'h1;
    localparam logic [1:0] MODE_CONTROL = 2'h2;
    localparam logic [1:0] MODE_SHIFT_CONTROL = 2'h3;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLOCK_MHZ = 125;
    localparam int SCAN_STEP_NS = 1000;
    localparam int SCAN_STEP_CYCLES = (SCAN_STEP_NS * CLOCK_MHZ) / 1000;
    localparam int DEBOUNCE_SCANS = 4;
    localparam logic [CODE_W-1:0] CODE_RESET = 9'h000;

    // decoded key event carried to the output stage
    typedef struct packed {
        logic [1:0] mode;
        logic [POS_W-1:0] pos;
    } kme_key_t;
endpackage : kme_pkg

// ### design/keyboard_matrix_encoder.sv
// Notes on behaviour
// - position count sits on bits 9..4 and 1
// - bit 9 is count LSB, bit 1 MSB
// - count equals ten times X plus Y
// - bits 2,3 carry modifier mode code
// - code only after stable debounce interval
// - lockout or rollover chosen by input pin
// - select high means lockout, default high
// - any-key-down high while any key closed
// - scan timing from internal step counter
module kme_keyboard_matrix_encoder #(
    parameter int STEP_CYCLES = kme_pkg::SCAN_STEP_CYCLES,
    parameter int DEBOUNCE = kme_pkg::DEBOUNCE_SCANS
) (
    input wire logic clock,
    input wire logic reset,
    output logic [kme_pkg::X_LINES-1:0] xDrive,
    input wire logic [kme_pkg::Y_LINES-1:0] ySense,
    input wire logic shiftKey,
    input wire logic controlKey,
    input wire logic lockoutSelect,
    output logic [kme_pkg::CODE_W:1] codeOut,
    output logic anyKeyDown,
    output logic dataReady
);
    localparam int XW = $clog2(kme_pkg::X_LINES);
    localparam int YW = $clog2(kme_pkg::Y_LINES);
    localparam int SW = $clog2(STEP_CYCLES + 1);
    localparam int DW = $clog2(DEBOUNCE + 1);
    localparam int NK = kme_pkg::X_LINES * kme_pkg::Y_LINES;
    // column 0 is driven first, out of reset
    localparam logic [kme_pkg::X_LINES-1:0] DRIVE_FIRST = {{(kme_pkg::X_LINES - 1){1'b0}}, 1'b1};

    typedef enum logic [1:0] {SCAN, CONFIRM, EMIT} kme_state_t;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    // scan group: step timer, column index and the registered drive word
    // key group: per-key history, debounce counter and the output stage
    kme_state_t state_reg, state_next;
    logic [SW-1:0] step_reg, step_next;
    logic [XW-1:0] xIdx_reg, xIdx_next;
    logic [kme_pkg::X_LINES-1:0] drive_reg, drive_next;
    logic [NK-1:0] down_reg, down_next;     // keys seen closed on last pass
    logic [NK-1:0] sent_reg, sent_next;     // keys already reported
    logic [DW-1:0] stable_reg, stable_next;
    logic [kme_pkg::POS_W-1:0] cand_reg, cand_next;
    logic [kme_pkg::CODE_W:1] code_reg, code_next;
    logic ready_reg, ready_next;
    logic anyPass_reg, anyPass_next;
    logic any_reg, any_next;
    logic stepTick;
    logic passEnd;
    kme_pkg::kme_key_t key;

    // ------------------------------------------------------------
    // scan drive: one X line high at a time
    // ------------------------------------------------------------
    // the drive word is registered beside the column index, so the lines
    // switch on the clock edge and never glitch through the decoder
    genvar gx;
    generate
        for (gx = 0; gx < kme_pkg::X_LINES; gx++) begin : g_drive
            assign drive_next[gx] = (xIdx_next == XW'(gx));
        end
    endgenerate

    // internal scan oscillator; no external scan clock needed
    // one column step lasts STEP_CYCLES clocks, a full pass nine steps
    assign stepTick = (step_reg == SW'(STEP_CYCLES - 1));
    assign passEnd = stepTick && (xIdx_reg == XW'(kme_pkg::X_LINES - 1));

    // the step timer wraps every STEP_CYCLES clocks and the column index
    // wraps after the last column, so a pass takes a fixed time
    always_comb begin
        step_next = stepTick ? '0 : step_reg + SW'(1);
        xIdx_next = xIdx_reg;
        if (stepTick) begin
            xIdx_next = passEnd ? '0 : xIdx_reg + XW'(1);
        end
    end

    // scan group registers
    always_ff @(posedge clock) begin
        if (reset) begin
            step_reg <= '0;
            xIdx_reg <= '0;
            drive_reg <= DRIVE_FIRST;
        end else begin
            step_reg <= step_next;
            xIdx_reg <= xIdx_next;
            drive_reg <= drive_next;
        end
    end

    // ------------------------------------------------------------
    // key state, debounce and encode
    // ------------------------------------------------------------
    // a key found new at a pass end becomes the candidate; it must then be
    // seen closed at DEBOUNCE further pass ends before its code is latched.
    // a key stays marked as sent until a whole pass sees it open, so a
    // held key is reported once and a repeat needs a real release
    always_comb begin
        logic [NK-1:0] newKeys;
        logic found;
        logic [kme_pkg::POS_W-1:0] firstNew;
        newKeys = '0;
        found = 1'b0;
        firstNew = '0;
        down_next = down_reg;
        sent_next = sent_reg;
        anyPass_next = anyPass_reg;
        any_next = any_reg;
        state_next = state_reg;
        stable_next = stable_reg;
        cand_next = cand_reg;
        code_next = code_reg;
        ready_next = 1'b0;
        // sample this column's Y lines near the end of the step
        if (stepTick) begin
            for (int y = 0; y < kme_pkg::Y_LINES; y++) begin
                down_next[int'(xIdx_reg) * kme_pkg::Y_LINES + y] = ySense[y];
            end
            if (|ySense) begin
                anyPass_next = 1'b1;
            end
        end
        if (passEnd) begin
            // any-key-down follows whole passes and lags a release by a pass or two
            any_next = anyPass_next;
            anyPass_next = 1'b0;
            sent_next = sent_reg & down_next; // released keys re-arm
            newKeys = down_next & ~sent_next;
            for (int k = NK - 1; k >= 0; k--) begin
                if (newKeys[k]) begin
                    found = 1'b1;
                    firstNew = kme_pkg::POS_W'(k);
                end
            end
        end
        unique case (state_reg)
            SCAN: begin
                // lockout holds off while another key is still down
                // rollover takes the lowest new position each pass; without
                // series diodes three closed keys can fake a fourth
                if (found && (!lockoutSelect || ($countones(down_next) == 1))) begin
                    cand_next = firstNew;
                    stable_next = '0;
                    state_next = CONFIRM;
                end
            end
            CONFIRM: begin
                if (passEnd) begin
                    if (!down_next[cand_reg] ||
                        (lockoutSelect && $countones(down_next) != 1)) begin
                        state_next = SCAN;
                    end else if (stable_reg == DW'(DEBOUNCE - 1)) begin
                        // pins 9 down to 4 carry pos[0..5], pin 3 shift, pin 2
                        // control and pin 1 the top position bit
                        code_next = {key.pos[0], key.pos[1], key.pos[2], key.pos[3],
                                     key.pos[4], key.pos[5], key.mode[0], key.mode[1],
                                     key.pos[6]};
                        sent_next[cand_reg] = 1'b1;
                        state_next = EMIT;
                    end else begin
                        stable_next = stable_reg + DW'(1);
                    end
                end
            end
            EMIT: begin
                // code already stable on pins a cycle before the pulse
                ready_next = 1'b1;
                state_next = SCAN;
            end
            default: begin
                // the spare state code only follows an upset; start over
                state_next = SCAN;
            end
        endcase
    end

    // ------------------------------------------------------------
    // modifier capture
    // ------------------------------------------------------------
    // mode word: bit 1 control, bit 0 shift, as the package codes it;
    // the modifiers are read at the edge that latches the code
    assign key.mode = {controlKey, shiftKey};
    assign key.pos = cand_reg;

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // key group registers; the code register keeps its value through
    // every scan so the host may read it at leisure
    always_ff @(posedge clock) begin
        if (reset) begin
            state_reg <= SCAN;
            down_reg <= '0;
            sent_reg <= '0;
            stable_reg <= '0;
            cand_reg <= '0;
            code_reg <= kme_pkg::CODE_RESET;
            ready_reg <= 1'b0;
            anyPass_reg <= 1'b0;
            any_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            down_reg <= down_next;
            sent_reg <= sent_next;
            stable_reg <= stable_next;
            cand_reg <= cand_next;
            code_reg <= code_next;
            ready_reg <= ready_next;
            anyPass_reg <= anyPass_next;
            any_reg <= any_next;
        end
    end

    // ------------------------------------------------------------
    // outputs, all straight from flip-flops
    // ------------------------------------------------------------
    assign xDrive = drive_reg;
    assign codeOut = code_reg;
    assign anyKeyDown = any_reg;
    assign dataReady = ready_reg;
endmodule : kme_keyboard_matrix_encoder

// ### testbench/kme_key_matrix.sv
// ----------------------------------------
// switch matrix seen from the scan lines
// ----------------------------------------
module kme_key_matrix (
    input wire logic [8:0] xDrive,
    input wire logic [89:0] keyDown,
    output logic [9:0] ySense
);
    timeunit 1ns;
    timeprecision 1ps;
    // key 10x+y joins column x to sense y; open lines read low (pull-down)
    always_comb begin
        ySense = 10'h000;
        for (int k = 0; k < 90; k++) begin
            if (keyDown[k] && xDrive[k / 10]) begin
                ySense[k % 10] = 1'b1;
            end
        end
    end
endmodule : kme_key_matrix

// ### testbench/kme_asserts.sv
// ----------------------------------------
// port checks
// ----------------------------------------
module kme_asserts #(
    parameter int STEP_CYCLES = kme_pkg::SCAN_STEP_CYCLES,
    parameter int DEBOUNCE = kme_pkg::DEBOUNCE_SCANS
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic [8:0] xDrive,
    input wire logic [9:1] codeOut,
    input wire logic shiftKey,
    input wire logic controlKey,
    input wire logic anyKeyDown,
    input wire logic dataReady
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clock);
    endclocking
    default disable iff (reset);
    logic [15:0] upCnt;
    logic [6:0] pos;
    assign pos = {codeOut[1], codeOut[4], codeOut[5], codeOut[6],
                  codeOut[7], codeOut[8], codeOut[9]};
    // saturating count of cycles with a key held
    always_ff @(posedge clock) begin
        upCnt <= (reset || !anyKeyDown) ? 16'h0000 : upCnt + 16'(upCnt != 16'hffff);
    end
    sequence sPulse;
        dataReady ##1 !dataReady;
    endsequence
    chk_drive_onehot: assert property ($onehot(xDrive)) else $error("bad drive");
    chk_drive_advance: assert property ($changed(xDrive) |->
        xDrive == ($past(xDrive[8]) ? 9'h001 : $past(xDrive) << 1)) else $error("bad step");
    chk_code_pulse: assert property ($changed(codeOut) |=> sPulse) else $error("no pulse");
    chk_ready_stable: assert property (dataReady |-> $stable(codeOut)) else $error("moved");
    chk_code_range: assert property (dataReady |-> pos < 7'h5a) else $error("bad pos");
    chk_mode_bits: assert property ($changed(codeOut) |-> codeOut[2] == $past(controlKey) &&
        codeOut[3] == $past(shiftKey)) else $error("bad mode");
    chk_ready_key: assert property (dataReady |-> anyKeyDown) else $error("idle ready");
    chk_debounce_min: assert property (dataReady |->
        upCnt >= (DEBOUNCE * 9 - 1) * STEP_CYCLES) else $error("early code");
endmodule : kme_asserts
bind kme_keyboard_matrix_encoder kme_asserts #(.STEP_CYCLES(STEP_CYCLES), .DEBOUNCE(DEBOUNCE))
    kme_asserts_i (.clock(clock), .reset(reset), .xDrive(xDrive), .codeOut(codeOut),
    .shiftKey(shiftKey), .controlKey(controlKey), .anyKeyDown(anyKeyDown), .dataReady(dataReady));

// ### testbench/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0, reset = 1'b1, shiftKey = 1'b0, controlKey = 1'b0, lockoutSelect = 1'b1;
    logic [89:0] keyDown = '0;
    logic [9:0] ySense;
    logic [8:0] xDrive;
    logic [9:1] codeOut;
    logic anyKeyDown, dataReady;
    int mismatches = 0, compares = 0;
    logic [15:0] rnd = 16'h4769;
    kme_keyboard_matrix_encoder #(.STEP_CYCLES(2), .DEBOUNCE(4)) kme_keyboard_matrix_encoder_i (
        .clock(clock), .reset(reset), .xDrive(xDrive), .ySense(ySense), .shiftKey(shiftKey),
        .controlKey(controlKey), .lockoutSelect(lockoutSelect), .codeOut(codeOut),
        .anyKeyDown(anyKeyDown), .dataReady(dataReady));
    kme_key_matrix kme_key_matrix_i (.xDrive(xDrive), .keyDown(keyDown), .ySense(ySense));
    initial begin
        forever #4 clock = ~clock;
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    // 16-bit xorshift with shifts 7, 9 and 8
    function automatic logic [15:0] next_rnd(input logic [15:0] s);
        logic [15:0] t;
        t = s ^ (s << 7);
        t = t ^ (t >> 9);
        t = t ^ (t << 8);
        return t;
    endfunction : next_rnd
    function automatic logic [9:1] exp_code(input int p, input logic sh, input logic ct);
        logic [6:0] q;
        q = 7'(p);
        return {q[0], q[1], q[2], q[3], q[4], q[5], sh, ct, q[6]};
    endfunction : exp_code
    task automatic check(input logic [9:1] got, input logic [9:1] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    // samples each falling edge until the first pulse or n cycles pass
    task automatic wait_ready(input int n, output logic seen);
        seen = 1'b0;
        repeat (n) if (!seen) begin
            @(negedge clock);
            seen = (dataReady === 1'b1);
        end
    endtask : wait_ready
    task automatic press(input int p, input logic want);
        logic seen;
        keyDown[p] = 1'b1;
        wait_ready(200, seen);
        check({8'h00, seen}, {8'h00, want});
        if (want) check(codeOut, exp_code(p, shiftKey, controlKey));
    endtask : press
    // over three passes with no key, so a held key counts as released
    task automatic release_all();
        keyDown = '0;
        repeat (60) @(negedge clock);
        check({8'h00, anyKeyDown}, 9'h000);
    endtask : release_all
    task automatic end_sim();
        if (mismatches == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_sim
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        int p;
        logic seen;
        repeat (10) @(posedge clock);
        @(negedge clock);
        reset = 1'b0;
        for (int i = 0; i < 12; i++) begin
            rnd = next_rnd(rnd);
            p = (i == 0) ? 0 : (i == 1) ? 89 : int'(rnd % 16'd90);
            {shiftKey, controlKey} = 2'(i);
            press(p, 1'b1);
            check({8'h00, anyKeyDown}, 9'h001);
            release_all();
        end
        // a one-pass closure is bounce, not a key
        keyDown[45] = 1'b1;
        repeat (18) @(negedge clock);
        keyDown[45] = 1'b0;
        wait_ready(150, seen);
        check({8'h00, seen}, 9'h000);
        press(12, 1'b1);
        press(57, 1'b0);
        release_all();
        lockoutSelect = 1'b0;
        press(12, 1'b1);
        press(57, 1'b1);
        release_all();
        end_sim();
    end
    // the sequence needs a few thousand cycles; this allows 50000
    initial begin
        #400000;
        mismatches++;
        end_sim();
    end
endmodule : testbench
